// file: logic/bit_sync.sv
`timescale 1ns/1ps
`include "scp_defs.svh"
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage_q [`SCP_SYNC_STAGES];

  // The first stage feeds only the second, never any logic.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_q[0] <= '0;
      stage_q[1] <= '0;
    end else begin
      stage_q[0] <= d;
      stage_q[1] <= stage_q[0];
    end
  end

  assign q = stage_q[1];
endmodule

// file: logic/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
// How it works
// - Serial writes land in the register file only on the system clock, so nothing happens without it.
// - Every incoming data bit is sampled on the rising edge of the shift clock.
// - Every readback bit is launched on the falling edge of the shift clock.
// - After reset the separate output enable bit at address 0x0000 is clear and the shared pin carries both directions.
// - With the separate output enable bit set, the shared pin is input only and readback leaves on the dedicated output.
// - The dedicated output carries readback only in unidirectional mode and stays undriven otherwise.
// - Transfers are accepted and performed only while the select input is held low.
// - While select is high both the shared pin and the dedicated output are released.
// - Single and multi byte transfers are supported in either MSB first or LSB first bit order.
// - Each cycle opens with a 16 bit instruction of read flag, two length bits and a 13 bit start address.
// - Length code 00, 01 and 10 move one, two and three data bytes and 11 streams without limit.
// - The register address steps down after each data byte in MSB first order and up in LSB first order.
// - Select rising off a byte boundary abandons the transfer and discards the partial byte.

// ****************************************************************
// Register map and fields.
// ****************************************************************
`define SCP_REG_CFG 13'h0000
`define SCP_REG_STATUS 13'h0001
`define SCP_CFG_SEP_OE_BIT 0
`define SCP_CFG_LSB_FIRST_BIT 1
`define SCP_CFG_RESET 8'h00
`define SCP_STATUS_ACTIVE_BIT 0

// ****************************************************************
// Instruction word layout.
// ****************************************************************
`define SCP_INSTR_RNW_BIT 15
`define SCP_INSTR_LEN_HI 14
`define SCP_INSTR_LEN_LO 13
`define SCP_INSTR_ADDR_HI 12
`define SCP_LEN_STREAM 2'h3

// ****************************************************************
// Timing.
// ****************************************************************
`define SCP_SYNC_STAGES 2
`endif

// file: logic/scp_pkg.sv
package scp_pkg;
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_DATA,
    PH_DONE
  } phase_t;
endpackage

// file: logic/serial_control_port_pins.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "scp_defs.svh"
module serial_control_port_pins #(
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic link_sclk,
  input wire logic port_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic dedicated_serial_out,
  output logic dedicated_serial_out_oe
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // System clock side: register file.
  // ****************************************************************
  logic [7:0] regs_q [DEPTH];
  logic [7:0] reg_rdata_q;
  logic [6:0] wr_count_q;
  logic wr_seen_q;
  logic wr_tgl_sync;
  logic active_sync;
  logic ser_wr;
  logic ser_hit;
  logic loc_hit;
  logic [7:0] status_byte;

  // Link side registers, declared here because the file reads them across.
  logic wr_tgl_q;
  logic [12:0] wr_addr_x_q;
  logic [7:0] wr_data_x_q;
  logic [12:0] addr_q;

  bit_sync #(.W(1)) u_wr_sync (
    .clk(sys_clk),
    .nrst(nrst),
    .d(wr_tgl_q),
    .q(wr_tgl_sync)
  );

  bit_sync #(.W(1)) u_act_sync (
    .clk(sys_clk),
    .nrst(nrst),
    .d(~port_select_n),
    .q(active_sync)
  );

  // The status byte is read only; writes to it and to addresses without storage are dropped.
  function automatic logic hit(input logic [12:0] a);
    hit = (a < 13'(DEPTH)) && (a != `SCP_REG_STATUS);
  endfunction

  function automatic logic [7:0] byte_at(input logic [12:0] a, input logic [7:0] st);
    if (a == `SCP_REG_STATUS) begin
      byte_at = st;
    end else if (a < 13'(DEPTH)) begin
      byte_at = regs_q[a[AW-1:0]];
    end else begin
      byte_at = 8'h00;
    end
  endfunction

  assign ser_wr = wr_tgl_sync != wr_seen_q;
  assign ser_hit = hit(wr_addr_x_q);
  assign loc_hit = hit(reg_addr);
  // Counting serial write data bytes lets local software see that a serial write has crossed over.
  assign status_byte = {wr_count_q, active_sync};

  // The serial write is applied by the system clock; with that clock stopped it stays pending.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs_q[i] <= 8'h00;
      end
      regs_q[0] <= `SCP_CFG_RESET;
      wr_seen_q <= 1'b0;
      wr_count_q <= 7'h00;
    end else begin
      wr_seen_q <= wr_tgl_sync;
      if (reg_wr && loc_hit) begin
        regs_q[reg_addr[AW-1:0]] <= reg_wdata;
      end
      // A serial write to the same byte in the same cycle wins over the local one.
      if (ser_wr && ser_hit) begin
        regs_q[wr_addr_x_q[AW-1:0]] <= wr_data_x_q;
      end
      if (ser_wr) begin
        wr_count_q <= wr_count_q + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? byte_at(reg_addr, status_byte) : 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;

  // ****************************************************************
  // Link side: instruction and data shifting on the shift clock.
  // ****************************************************************
  logic [1:0] cfg_link;
  logic sep_oe;
  logic lsb_first;
  logic [2:0] bit_cnt_q;
  logic ibyte_q;
  logic [15:0] instr_q;
  logic [7:0] byte_sh_q;
  scp_pkg::phase_t phase_q;
  logic rnw_q;
  logic [1:0] len_q;
  logic [1:0] left_q;
  logic brk_tgl_q;
  logic brk_ack_q;
  logic restart;
  logic [2:0] bc;
  scp_pkg::phase_t ph;
  logic byte_done;
  logic [15:0] instr_next;
  logic [15:0] instr_rev;
  logic [15:0] instr_dec;
  logic [7:0] data_next;
  logic [7:0] data_rev;
  logic [7:0] data_dec;
  logic [12:0] addr_step;

  // The mode bits need two shift clock edges to reach the link, so a new mode is only safe
  // for a frame that starts after a few edges of an earlier one.
  bit_sync #(.W(2)) u_cfg_sync (
    .clk(link_sclk),
    .nrst(nrst),
    .d({regs_q[0][`SCP_CFG_LSB_FIRST_BIT], regs_q[0][`SCP_CFG_SEP_OE_BIT]}),
    .q(cfg_link)
  );

  assign sep_oe = cfg_link[0];
  assign lsb_first = cfg_link[1];

  // A select rise that left the port mid-byte, streaming or finished is seen as a toggle.
  assign restart = brk_tgl_q != brk_ack_q;
  assign bc = restart ? 3'h0 : bit_cnt_q;
  assign ph = restart ? scp_pkg::PH_INSTR : phase_q;
  assign byte_done = bc == 3'h7;
  assign instr_next = {(restart ? 15'h0000 : instr_q[14:0]), sdio_in};
  assign data_next = {byte_sh_q[6:0], sdio_in};

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_rev16
      assign instr_rev[g] = instr_next[15-g];
    end
    for (g = 0; g < 8; g++) begin : g_rev8
      assign data_rev[g] = data_next[7-g];
    end
  endgenerate

  assign instr_dec = lsb_first ? instr_rev : instr_next;
  assign data_dec = lsb_first ? data_rev : data_next;
  assign addr_step = lsb_first ? addr_q + 13'h0001 : addr_q - 13'h0001;

  always_ff @(posedge link_sclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= 3'h0;
      ibyte_q <= 1'b0;
      instr_q <= 16'h0000;
      byte_sh_q <= 8'h00;
      phase_q <= scp_pkg::PH_INSTR;
      rnw_q <= 1'b0;
      len_q <= 2'h0;
      left_q <= 2'h0;
      addr_q <= 13'h0000;
      brk_ack_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      wr_addr_x_q <= 13'h0000;
      wr_data_x_q <= 8'h00;
    end else if (!port_select_n) begin
      brk_ack_q <= brk_tgl_q;
      bit_cnt_q <= bc + 3'h1;
      case (ph)
        scp_pkg::PH_INSTR: begin
          instr_q <= instr_next;
          if (restart) begin
            ibyte_q <= 1'b0;
          end else if (byte_done) begin
            ibyte_q <= ~ibyte_q;
          end
          if (byte_done && ibyte_q && !restart) begin
            rnw_q <= instr_dec[`SCP_INSTR_RNW_BIT];
            len_q <= instr_dec[`SCP_INSTR_LEN_HI:`SCP_INSTR_LEN_LO];
            left_q <= instr_dec[`SCP_INSTR_LEN_HI:`SCP_INSTR_LEN_LO];
            addr_q <= instr_dec[`SCP_INSTR_ADDR_HI:0];
            phase_q <= scp_pkg::PH_DATA;
          end else begin
            phase_q <= scp_pkg::PH_INSTR;
          end
        end
        scp_pkg::PH_DATA: begin
          byte_sh_q <= data_next;
          if (byte_done) begin
            if (!rnw_q) begin
              wr_addr_x_q <= addr_q;
              wr_data_x_q <= data_dec;
              wr_tgl_q <= ~wr_tgl_q;
            end
            addr_q <= addr_step;
            if (len_q != `SCP_LEN_STREAM) begin
              if (left_q == 2'h0) begin
                phase_q <= scp_pkg::PH_DONE;
              end else begin
                left_q <= left_q - 2'h1;
              end
            end
          end
        end
        scp_pkg::PH_DONE: begin
          phase_q <= scp_pkg::PH_DONE;
        end
        default: begin
          phase_q <= scp_pkg::PH_INSTR;
        end
      endcase
    end
  end

  // ****************************************************************
  // Select rise: decides between stall and abandon.
  // ****************************************************************
  // The link state is still while select rises, because the shift clock is idle then.
  logic brk_cond;
  logic brk_take;
  assign brk_cond = (bit_cnt_q != 3'h0) || (phase_q == scp_pkg::PH_DONE)
    || ((phase_q == scp_pkg::PH_DATA) && (len_q == `SCP_LEN_STREAM));
  // A second rise before the link has taken the first must not cancel it, or the frame after
  // an empty select pulse would start where the old one stopped.
  assign brk_take = brk_cond && !restart;

  always_ff @(posedge port_select_n or negedge nrst) begin
    if (!nrst) begin
      brk_tgl_q <= 1'b0;
    end else if (brk_take) begin
      brk_tgl_q <= ~brk_tgl_q;
    end
  end

  // ****************************************************************
  // Readback launch on the falling shift clock edge.
  // ****************************************************************
  // Register contents are read across without a handshake; they are treated as
  // quasi-static, so a local write during a serial read of the same byte may tear.
  logic oe_clr;
  logic drive;
  logic [7:0] rd_byte;
  logic [7:0] rd_hold_q;
  logic [7:0] rd_src;
  logic [2:0] bit_sel;
  logic sdio_out_q;
  logic sdio_oe_q;
  logic dso_q;
  logic dso_oe_q;

  // Both readback pins load on every falling edge; the enables alone decide what the host sees.
  assign oe_clr = port_select_n | ~nrst;
  assign drive = (phase_q == scp_pkg::PH_DATA) && rnw_q;
  assign rd_byte = byte_at(addr_q, status_byte);
  assign rd_src = (bit_cnt_q == 3'h0) ? rd_byte : rd_hold_q;
  assign bit_sel = lsb_first ? bit_cnt_q : 3'h7 - bit_cnt_q;

  always_ff @(negedge link_sclk or posedge oe_clr) begin
    if (oe_clr) begin
      rd_hold_q <= 8'h00;
      sdio_out_q <= 1'b0;
      dso_q <= 1'b0;
      sdio_oe_q <= 1'b0;
      dso_oe_q <= 1'b0;
    end else begin
      if (bit_cnt_q == 3'h0) begin
        rd_hold_q <= rd_byte;
      end
      sdio_out_q <= rd_src[bit_sel];
      dso_q <= rd_src[bit_sel];
      sdio_oe_q <= drive && !sep_oe;
      dso_oe_q <= drive && sep_oe;
    end
  end

  assign sdio_out = sdio_out_q;
  assign sdio_oe = sdio_oe_q;
  assign dedicated_serial_out = dso_q;
  assign dedicated_serial_out_oe = dso_oe_q;
endmodule

// file: verif/scp_host.sv
`timescale 1ns/1ps
// ****
// Serial host model.
// ****
module scp_host (
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic dedicated_serial_out,
  input wire logic dedicated_serial_out_oe,
  output logic link_sclk,
  output logic port_select_n,
  output logic sdio_in
);
  logic host_d = 1'b0;
  logic host_oe = 1'b0;
  logic junk = 1'b0;
  // A released line toggles each bit, so a stale value can never pass for read data.
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : junk);
  initial link_sclk = 1'b0;
  initial port_select_n = 1'b1;
  task automatic sel(input logic v);
    #10;
    port_select_n = v;
    #10;
  endtask
  task automatic shift(input int n, input logic [15:0] w, input bit lsb, input bit drv,
    input bit sep, output logic [15:0] r);
    int idx;
    r = 16'h0000;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : n - 1 - i;
      host_oe = drv;
      host_d = w[idx];
      junk = ~junk;
      #20;
      r[idx] = sep ? (dedicated_serial_out_oe ? dedicated_serial_out : junk) : sdio_in;
      link_sclk = 1'b1;
      #40;
      link_sclk = 1'b0;
      #20;
    end
    host_oe = 1'b0;
  endtask
endmodule

// file: verif/scp_monitor.sv
`timescale 1ns/1ps
// ****
// Pin checker.
// ****
module scp_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic link_sclk,
  input wire logic port_select_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic dedicated_serial_out,
  input wire logic dedicated_serial_out_oe
);
  logic [4:0] cnt_q;
  logic [15:0] ins_q;
  logic [1:0] cfg_q;
  // Mode follows local writes only, so serial writes to the mode byte are not tracked.
  wire rnw = cfg_q[1] ? ins_q[0] : ins_q[15];
  always_ff @(posedge link_sclk or negedge nrst or posedge port_select_n) begin
    if (!nrst || port_select_n) begin
      cnt_q <= 5'h00;
      ins_q <= 16'h0000;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q < 5'h10)
        ins_q <= {ins_q[14:0], sdio_in};
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      cfg_q <= 2'h0;
    else if (reg_wr && reg_addr == 13'h0000)
      cfg_q <= reg_wdata[1:0];
  end
  a_sel_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    port_select_n |-> !sdio_oe && !dedicated_serial_out_oe) else $error("pin driven unselected");
  a_bidir_no_ded: assert property (@(posedge sys_clk) disable iff (!nrst)
    !cfg_q[0] |-> !dedicated_serial_out_oe) else $error("separate output driven in bidir");
  a_sep_no_sdio: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_q[0] |-> !sdio_oe) else $error("shared pin driven in unidirectional mode");
  a_instr_quiet: assert property (@(posedge link_sclk) disable iff (!nrst)
    cnt_q < 5'h10 |-> !sdio_oe && !dedicated_serial_out_oe) else $error("driven in instruction");
  a_write_quiet: assert property (@(posedge link_sclk) disable iff (!nrst)
    cnt_q >= 5'h10 && !rnw |-> !sdio_oe && !dedicated_serial_out_oe) else $error("driven in write");
  a_read_drives: assert property (@(posedge link_sclk) disable iff (!nrst)
    cnt_q inside {[5'h10:5'h17]} && rnw |-> (cfg_q[0] ? dedicated_serial_out_oe : sdio_oe))
    else $error("readback pin not driven");
  a_launch_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sdio_oe && $changed(sdio_out)) || (dedicated_serial_out_oe && $changed(dedicated_serial_out))
    |-> !link_sclk) else $error("read bit changed while shift clock high");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
endmodule

// file: verif/serial_control_port_pins_tb.sv
`timescale 1ns/1ps
// ****
// Self-checking bench.
// ****
module serial_control_port_pins_tb;
  logic sys_clk;
  logic nrst;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  wire link_sclk;
  wire port_select_n;
  wire sdio_in;
  wire sdio_out;
  wire sdio_oe;
  wire dedicated_serial_out;
  wire dedicated_serial_out_oe;
  int failures;
  int tests_run;
  int seed;
  int nwr;
  logic [7:0] mem [8192];
  logic [15:0] r;
  serial_control_port_pins u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_sclk(link_sclk),
    .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .dedicated_serial_out(dedicated_serial_out),
    .dedicated_serial_out_oe(dedicated_serial_out_oe)
  );
  scp_host u_host (
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .dedicated_serial_out(dedicated_serial_out),
    .dedicated_serial_out_oe(dedicated_serial_out_oe), .link_sclk(link_sclk),
    .port_select_n(port_select_n), .sdio_in(sdio_in)
  );
  always #20 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [12:0] step(input logic [12:0] a, input int k, input bit lsb);
    return lsb ? a + 13'(k) : a - 13'(k);
  endfunction
  task automatic frame(input bit rnw, input logic [12:0] a, input logic [1:0] len,
    input logic [7:0] cfg);
    int nb;
    logic [7:0] d;
    logic [7:0] v;
    nb = (len == 2'h3) ? 4 : len + 1;
    u_host.sel(1'b0);
    u_host.shift(16, {rnw, len, a}, cfg[1], 1'b1, 1'b0, r);
    for (int k = 0; k < nb; k++) begin
      d = $random(seed);
      u_host.shift(8, {8'h00, d}, cfg[1], !rnw || cfg[0], cfg[0], r);
      if (rnw) begin
        check(r[7:0], mem[step(a, k, cfg[1])]);
      end else begin
        mem[step(a, k, cfg[1])] = d;
        nwr++;
      end
    end
    u_host.sel(1'b1);
    repeat (6) @(posedge sys_clk);
    rd(step(a, nb - 1, cfg[1]), v);
    check(v, mem[step(a, nb - 1, cfg[1])]);
  endtask
  task automatic set_cfg(input logic [7:0] c);
    logic [7:0] v;
    wr(13'h0000, c);
    mem[0] = c;
    rd(13'h0000, v);
    check(v, c);
    // A short abandoned frame gives the new mode the link edges it needs to cross.
    u_host.sel(1'b0);
    u_host.shift(4, 16'($random(seed)), c[1], 1'b1, c[0], r);
    u_host.sel(1'b1);
  endtask
  initial begin
    logic [7:0] v;
    logic [12:0] a;
    sys_clk = 1'b0;
    nrst = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    tests_run = 0;
    seed = 53849;
    nwr = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(13'h0000, v);
    check(v, 8'h00);
    rd(13'h1000, v);
    check(v, 8'h00);
    for (int m = 0; m < 4; m++) begin
      set_cfg(8'(m));
      for (int len = 0; len < 4; len++) begin
        a = 13'h0004 + 13'($unsigned($random(seed)) % 5);
        if (!m[1])
          a = 13'h0013 - a;
        frame(1'b0, a, 2'(len), 8'(m));
        frame(1'b1, a, 2'(len), 8'(m));
      end
    end
    set_cfg(8'h00);
    v = $random(seed);
    wr(13'h0009, v);
    mem[9] = v;
    u_host.sel(1'b0);
    u_host.shift(16, {1'b0, 2'h0, 13'h0009}, 1'b0, 1'b1, 1'b0, r);
    u_host.shift(5, {8'h00, ~v}, 1'b0, 1'b1, 1'b0, r);
    u_host.sel(1'b1);
    repeat (6) @(posedge sys_clk);
    rd(13'h0009, v);
    check(v, mem[9]);
    // Status is read only; an empty select pulse must not undo the pending restart.
    wr(13'h0001, 8'hff);
    u_host.sel(1'b0);
    repeat (3) @(posedge sys_clk);
    rd(13'h0001, v);
    check(v, {7'(nwr), 1'b1});
    u_host.sel(1'b1);
    repeat (3) @(posedge sys_clk);
    rd(13'h0001, v);
    check(v, {7'(nwr), 1'b0});
    frame(1'b1, 13'h0009, 2'h0, 8'h00);
    print_verdict;
  end
  initial begin
    #3000000;
    failures++;
    print_verdict;
  end
endmodule
bind serial_control_port_pins scp_monitor u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_sclk(link_sclk),
  .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .dedicated_serial_out(dedicated_serial_out),
  .dedicated_serial_out_oe(dedicated_serial_out_oe)
);
